// ### shared/tuning_pkg.sv
// Purpose: constants for the switch tuning configuration register bank
// Assumes: 32-bit configuration dword access, byte enables per lane
// Notes:   offsets are byte addresses within configuration space
package tuning_pkg;
   localparam int          ADDR_W            = 8;
   localparam int          DATA_W            = 32;
   localparam logic [7:0]  OFS_TEST_A        = 8'h68;
   localparam logic [7:0]  OFS_TEST_B        = 8'h6c;
   localparam logic [7:0]  OFS_TIMER         = 8'h70;
   localparam logic [7:0]  OFS_OPMODE        = 8'h74;
   localparam logic [31:0] RST_TEST_A        = 32'h0400_1060;
   localparam logic [31:0] RST_TEST_B        = 32'h0000_0800;
   // timer override word fields
   localparam int          RPL_LSB           = 0;
   localparam int          RPL_W             = 12;
   localparam int          RPL_EN_BIT        = 12;
   localparam int          PM_CAP_DIS_BIT    = 13;
   localparam int          MSI_CAP_DIS_BIT   = 14;
   localparam int          ACK_LSB           = 16;
   localparam int          ACK_W             = 14;
   localparam int          ACK_EN_BIT        = 30;
   localparam int          VGA_BIT           = 31;
   localparam logic [11:0] RST_RPL           = 12'h000;
   localparam logic [13:0] RST_ACK           = 14'h0000;
   localparam logic        RST_VGA           = 1'b1;
   // operation mode fields
   localparam int          SF_BIT            = 0;
   localparam int          CT_LSB            = 1;
   localparam int          ARB_BIT           = 3;
   localparam int          CRD_BIT           = 4;
   localparam int          EGR_BIT           = 5;
   localparam int          TAG_BIT           = 6;
   localparam logic [1:0]  RST_CT            = 2'h1;
   // built-in timer defaults used when no override is enabled
   localparam logic [11:0] DEF_RPL           = 12'h100;
   localparam logic [13:0] DEF_ACK           = 14'h0040;
   // width in bits of the cut-through threshold code field
   localparam int          CT_LEAD_W         = 2;
endpackage

// ### src/tuning_field.sv
// Purpose: one byte-enabled read-write register field with a loadable default
// Assumes: load and write never matter in the same cycle beyond load priority
// Notes:   default load replaces the reset value (smbus or eeprom source)
module tuning_field #(
   parameter int          W   = 32,
   parameter logic [31:0] RST = 32'h0
) (
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic          wr,
   input  wire logic [3:0]    be,
   input  wire logic [31:0]   wdata,
   input  wire logic          load,
   input  wire logic [31:0]   ldata,
   output logic      [W-1:0]  q
);
   if (W < 1 || W > 32) begin : g_width_check
      $error("tuning_field width out of range");
   end

   typedef struct packed {
      logic [W-1:0] val;
   } field_state_t;

   field_state_t state;
   field_state_t next_state;
   logic [31:0]  cur;
   logic [31:0]  merged;

   always_comb begin
      cur = 32'h0;
      cur[W-1:0] = state.val;
      merged = cur;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merged[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      next_state = state;
      if (load) begin
         next_state.val = ldata[W-1:0];
      end else if (wr) begin
         next_state.val = merged[W-1:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state.val <= RST[W-1:0];
      end else begin
         state <= next_state;
      end
   end

   assign q = state.val;
endmodule

// ### src/switch_tuning_config_regs.sv
// Purpose: configuration registers tuning forwarding and link-layer timers
// Assumes: config accesses are dword, one cycle strobes, synchronous to sys_clk
// Notes:   read data answers one cycle after the read strobe
//
// Function
// - a 12-bit read-write user replay timeout sits in bits 11:0 of the timer word, reset zero.
// - with the replay enable bit set, the programmed value is the replay timeout; enable resets 0.
// - a 14-bit read-write user ack latency sits in bits 29:16 of the timer word, reset zero.
// - with bit 30 set, the programmed value is the ack latency; enable resets zero.
// - reset defaults of the tuning fields may be replaced by smbus or eeprom loaded values.
// - bit 31 of the timer word is a read-only legacy video decode enable reading one.
// - store-and-forward bit set means whole packets first, clear means cut-through; reset 0.
// - threshold code 00 starts at the midpoint, 01/10/11 start 1/2/3 cycles earlier; reset 01.
// - arbitration bit set holds the granted port while its request pends despite low credit.
// - arbitration bit clear moves to a requesting port with enough credit; reset setting.
// - credit mode bit set releases freed credits of all types together per update.
// - credit mode bit clear, the reset value, releases credits per type per update.
// - egress ordering bit set applies ordering across egress ports; reset zero.
// - completion tag ordering bit set orders completions with different tags; reset zero.
// - test control word a at 68h is read-write 32 bits, reset 0400_1060h.
// - test control word b at 6ch is read-write 32 bits, reset 0000_0800h.
module switch_tuning_config_regs (
   input  wire logic                       sys_clk,
   input  wire logic                       rst,
   input  wire logic                       cfg_wr,
   input  wire logic                       cfg_rd,
   input  wire logic [tuning_pkg::ADDR_W-1:0] cfg_addr,
   input  wire logic [3:0]                 cfg_be,
   input  wire logic [tuning_pkg::DATA_W-1:0] cfg_wdata,
   input  wire logic                       dflt_load,
   input  wire logic [tuning_pkg::ADDR_W-1:0] dflt_addr,
   input  wire logic [tuning_pkg::DATA_W-1:0] dflt_data,
   output logic      [tuning_pkg::DATA_W-1:0] cfg_rdata,
   output logic                            cfg_rvalid,
   output logic      [11:0]                replay_timeout,
   output logic      [13:0]                ack_latency,
   output logic                            store_forward,
   output logic      [1:0]                 ct_lead_cycles,
   output logic                            arb_hold_grant,
   output logic                            credit_all_types,
   output logic                            egress_ordering,
   output logic                            cpl_tag_ordering,
   output logic                            vga_decode_en,
   output logic      [31:0]                test_ctrl_a,
   output logic      [31:0]                test_ctrl_b
);
   import tuning_pkg::*;

   // ************************************************************
   // register fields
   // ************************************************************
   logic        wr_a;
   logic        wr_b;
   logic        wr_t;
   logic        wr_m;
   logic        ld_a;
   logic        ld_b;
   logic        ld_t;
   logic        ld_m;
   logic [31:0] q_a;
   logic [31:0] q_b;
   logic [31:0] q_t;
   logic [6:0]  q_m;
   logic [31:0] rd_word;
   logic [31:0] timer_wr_word;
   logic [31:0] timer_ld_word;

   assign wr_a = cfg_wr && cfg_addr == OFS_TEST_A;
   assign wr_b = cfg_wr && cfg_addr == OFS_TEST_B;
   assign wr_t = cfg_wr && cfg_addr == OFS_TIMER;
   assign wr_m = cfg_wr && cfg_addr == OFS_OPMODE;
   assign ld_a = dflt_load && dflt_addr == OFS_TEST_A;
   assign ld_b = dflt_load && dflt_addr == OFS_TEST_B;
   assign ld_t = dflt_load && dflt_addr == OFS_TIMER;
   assign ld_m = dflt_load && dflt_addr == OFS_OPMODE;

   tuning_field #(.W(32), .RST(RST_TEST_A)) u_test_a (
      .sys_clk (sys_clk),
      .rst     (rst),
      .wr      (wr_a),
      .be      (cfg_be),
      .wdata   (cfg_wdata),
      .load    (ld_a),
      .ldata   (dflt_data),
      .q       (q_a)
   );

   tuning_field #(.W(32), .RST(RST_TEST_B)) u_test_b (
      .sys_clk (sys_clk),
      .rst     (rst),
      .wr      (wr_b),
      .be      (cfg_be),
      .wdata   (cfg_wdata),
      .load    (ld_b),
      .ldata   (dflt_data),
      .q       (q_b)
   );

   // timer word: bits 13,14 are read-only capability disables, loadable only
   tuning_field #(.W(32), .RST({RST_VGA, 1'b0, RST_ACK, 3'h0, 1'b0, RST_RPL})) u_timer (
      .sys_clk (sys_clk),
      .rst     (rst),
      .wr      (1'b0),
      .be      (4'h0),
      .wdata   (32'h0),
      .load    (ld_t || wr_t),
      .ldata   (ld_t ? timer_ld_word : timer_wr_word),
      .q       (q_t)
   );

   always_comb begin
      // reserved bit 15 stays zero even when a loaded default sets it
      timer_ld_word     = dflt_data;
      timer_ld_word[15] = 1'b0;
      timer_wr_word = q_t;
      for (int i = 0; i < 4; i++) begin
         if (cfg_be[i]) begin
            timer_wr_word[i*8 +: 8] = cfg_wdata[i*8 +: 8];
         end
      end
      // software may not alter read-only bits
      timer_wr_word[PM_CAP_DIS_BIT]  = q_t[PM_CAP_DIS_BIT];
      timer_wr_word[MSI_CAP_DIS_BIT] = q_t[MSI_CAP_DIS_BIT];
      timer_wr_word[15]              = 1'b0;
      timer_wr_word[VGA_BIT]         = q_t[VGA_BIT];
   end

   tuning_field #(.W(7), .RST({25'h0, 4'h0, RST_CT, 1'b0})) u_opmode (
      .sys_clk (sys_clk),
      .rst     (rst),
      .wr      (wr_m),
      .be      (cfg_be),
      .wdata   (cfg_wdata),
      .load    (ld_m),
      .ldata   (dflt_data),
      .q       (q_m)
   );

   // ************************************************************
   // state: read port and decoded controls, all registered
   // ************************************************************
   typedef struct packed {
      logic [31:0] rdata;
      logic        rvalid;
      logic [11:0] rpl;
      logic [13:0] ack;
      logic        sf;
      logic [1:0]  lead;
      logic        arb;
      logic        crd;
      logic        egr;
      logic        tag;
      logic        vga;
      logic [31:0] ta;
      logic [31:0] tb;
   } regs_state_t;

   regs_state_t state;
   regs_state_t next_state;

   always_comb begin
      case (cfg_addr)
         OFS_TEST_A: rd_word = q_a;
         OFS_TEST_B: rd_word = q_b;
         OFS_TIMER:  rd_word = q_t;
         OFS_OPMODE: rd_word = {25'h0, q_m};
         default:    rd_word = 32'h0;
      endcase
   end

   always_comb begin
      next_state        = state;
      next_state.rvalid = cfg_rd;
      next_state.rdata  = cfg_rd ? rd_word : 32'h0;
      next_state.rpl = q_t[RPL_EN_BIT] ? q_t[RPL_LSB +: RPL_W] : DEF_RPL;
      next_state.ack = q_t[ACK_EN_BIT] ? q_t[ACK_LSB +: ACK_W] : DEF_ACK;
      next_state.sf   = q_m[SF_BIT];
      next_state.lead = q_m[CT_LSB +: CT_LEAD_W];
      next_state.arb  = q_m[ARB_BIT];
      next_state.crd  = q_m[CRD_BIT];
      next_state.egr  = q_m[EGR_BIT];
      next_state.tag  = q_m[TAG_BIT];
      next_state.vga  = q_t[VGA_BIT];
      next_state.ta   = q_a;
      next_state.tb   = q_b;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state      <= '0;
         state.rpl  <= DEF_RPL;
         state.ack  <= DEF_ACK;
         state.lead <= RST_CT;
         state.vga  <= RST_VGA;
         state.ta   <= RST_TEST_A;
         state.tb   <= RST_TEST_B;
      end else begin
         state <= next_state;
      end
   end

   assign cfg_rdata        = state.rdata;
   assign cfg_rvalid       = state.rvalid;
   assign replay_timeout   = state.rpl;
   assign ack_latency      = state.ack;
   assign store_forward    = state.sf;
   assign ct_lead_cycles   = state.lead;
   assign arb_hold_grant   = state.arb;
   assign credit_all_types = state.crd;
   assign egress_ordering  = state.egr;
   assign cpl_tag_ordering = state.tag;
   assign vga_decode_en    = state.vga;
   assign test_ctrl_a      = state.ta;
   assign test_ctrl_b      = state.tb;

   // ************************************************************
   // assertions
   // ************************************************************
   property p_rpl_user;
      @(posedge sys_clk) disable iff (rst)
      q_t[RPL_EN_BIT] && !ld_t && !wr_t |=> ##1 replay_timeout == $past(q_t[11:0], 2);
   endproperty
   a_rpl_user: assert property (p_rpl_user) else $error("replay override not used");

   property p_rpl_dflt;
      @(posedge sys_clk) disable iff (rst)
      !q_t[RPL_EN_BIT] |=> replay_timeout == DEF_RPL;
   endproperty
   a_rpl_dflt: assert property (p_rpl_dflt) else $error("replay default not used");

   property p_ack_user;
      @(posedge sys_clk) disable iff (rst)
      q_t[ACK_EN_BIT] |=> ack_latency == $past(q_t[29:16]);
   endproperty
   a_ack_user: assert property (p_ack_user) else $error("ack override not used");

   property p_ack_dflt;
      @(posedge sys_clk) disable iff (rst)
      !q_t[ACK_EN_BIT] |=> ack_latency == DEF_ACK;
   endproperty
   a_ack_dflt: assert property (p_ack_dflt) else $error("ack default not used");

   property p_vga_ro;
      @(posedge sys_clk) disable iff (rst)
      wr_t && !ld_t |=> q_t[VGA_BIT] == $past(q_t[VGA_BIT]);
   endproperty
   a_vga_ro: assert property (p_vga_ro) else $error("vga bit changed by write");

   property p_wr_a;
      @(posedge sys_clk) disable iff (rst)
      wr_a && !ld_a && cfg_be == 4'hf |=> ##1 test_ctrl_a == $past(cfg_wdata, 2);
   endproperty
   a_wr_a: assert property (p_wr_a) else $error("test word a write lost");

   property p_rd_b;
      @(posedge sys_clk) disable iff (rst)
      cfg_rd && cfg_addr == OFS_TEST_B |=> cfg_rvalid && cfg_rdata == $past(q_b);
   endproperty
   a_rd_b: assert property (p_rd_b) else $error("test word b read wrong");

   property p_mode;
      @(posedge sys_clk) disable iff (rst)
      wr_m && !ld_m && cfg_be[0] |=> ##1 store_forward == $past(cfg_wdata[SF_BIT], 2)
         && ct_lead_cycles == $past(cfg_wdata[2:1], 2) && arb_hold_grant == $past(cfg_wdata[3], 2);
   endproperty
   a_mode: assert property (p_mode) else $error("mode controls not following write");

   property p_ld;
      @(posedge sys_clk) disable iff (rst)
      ld_m |=> ##1 credit_all_types == $past(dflt_data[CRD_BIT], 2)
         && egress_ordering == $past(dflt_data[EGR_BIT], 2)
         && cpl_tag_ordering == $past(dflt_data[TAG_BIT], 2);
   endproperty
   a_ld: assert property (p_ld) else $error("default load not applied");

   c_wr_timer: cover property (@(posedge sys_clk) disable iff (rst) wr_t);
   c_ld_mode:  cover property (@(posedge sys_clk) disable iff (rst) ld_m);
   c_sf_on:    cover property (@(posedge sys_clk) disable iff (rst) store_forward);
   c_rd_a:     cover property (@(posedge sys_clk) disable iff (rst) cfg_rd && cfg_addr == OFS_TEST_A);
endmodule

// ### bench/tb.sv
// Purpose: self-checking bench for the switch tuning register bank
// Assumes: dword config access, read data one cycle after the strobe
// Notes:   reads queue their expectation; a falling-edge monitor retires them
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tuning_pkg::*;

   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        cfg_wr = 1'b0;
   logic        cfg_rd = 1'b0;
   logic        dflt_load = 1'b0;
   logic [7:0]  cfg_addr = 8'h00;
   logic [7:0]  dflt_addr = 8'h00;
   logic [3:0]  cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic [31:0] dflt_data = 32'h0;
   logic [31:0] cfg_rdata;
   logic        cfg_rvalid;
   logic [11:0] replay_timeout;
   logic [13:0] ack_latency;
   logic        store_forward;
   logic [1:0]  ct_lead_cycles;
   logic        arb_hold_grant;
   logic        credit_all_types;
   logic        egress_ordering;
   logic        cpl_tag_ordering;
   logic        vga_decode_en;
   logic [31:0] test_ctrl_a;
   logic [31:0] test_ctrl_b;
   int          mismatches = 0;
   int          checked = 0;
   logic [31:0] expq[$];
   logic [31:0] shadow[4];
   logic [31:0] r;

   always #20 sys_clk = ~sys_clk;

   switch_tuning_config_regs uut (.sys_clk(sys_clk), .rst(rst), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
      .dflt_load(dflt_load), .dflt_addr(dflt_addr), .dflt_data(dflt_data),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .replay_timeout(replay_timeout),
      .ack_latency(ack_latency), .store_forward(store_forward),
      .ct_lead_cycles(ct_lead_cycles), .arb_hold_grant(arb_hold_grant),
      .credit_all_types(credit_all_types), .egress_ordering(egress_ordering),
      .cpl_tag_ordering(cpl_tag_ordering), .vga_decode_en(vga_decode_en),
      .test_ctrl_a(test_ctrl_a), .test_ctrl_b(test_ctrl_b));

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] wmask(input logic [7:0] a);
      case (a)
         OFS_TEST_A, OFS_TEST_B: return 32'hffff_ffff;
         OFS_TIMER: return 32'h7fff_1fff;
         OFS_OPMODE: return 32'h0000_007f;
         default: return 32'h0000_0000;
      endcase
   endfunction

   task automatic model_reset();
      shadow[0] = 32'h8000_0000;
      shadow[1] = {29'h0, RST_CT, 1'b0};
      shadow[2] = RST_TEST_A;
      shadow[3] = RST_TEST_B;
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      logic [31:0] m;
      logic [31:0] n;
      m = wmask(a);
      n = shadow[a[3:2]];
      for (int i = 0; i < 4; i++)
         if (be[i])
            n[8*i+:8] = d[8*i+:8];
      shadow[a[3:2]] = (shadow[a[3:2]] & ~m) | (n & m);
      @(posedge sys_clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_be <= be;
      cfg_wdata <= d;
      @(posedge sys_clk);
      cfg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      expq.push_back((wmask(a) != 32'h0) ? shadow[a[3:2]] : 32'h0);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge sys_clk);
      cfg_rd <= 1'b0;
   endtask

   // default load, optionally colliding with a software write of the inverse
   task automatic ld(input logic [7:0] a, input logic [31:0] d, input logic with_wr);
      @(posedge sys_clk);
      dflt_load <= 1'b1;
      dflt_addr <= a;
      dflt_data <= d;
      cfg_wr <= with_wr;
      cfg_addr <= a;
      cfg_be <= 4'hf;
      cfg_wdata <= ~d;
      @(posedge sys_clk);
      dflt_load <= 1'b0;
      cfg_wr <= 1'b0;
      shadow[a[3:2]] = d & ((a == OFS_TIMER) ? 32'hffff_7fff : wmask(a));
   endtask

   // controls lag a write by two cycles, so look after the third edge
   task automatic ctl(input string t);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("replay", shadow[0][RPL_EN_BIT] ? 32'(shadow[0][11:0]) : 32'(DEF_RPL),
          32'(replay_timeout));
      chk("ack", shadow[0][ACK_EN_BIT] ? 32'(shadow[0][29:16]) : 32'(DEF_ACK),
          32'(ack_latency));
      chk("vga", 32'(shadow[0][VGA_BIT]), 32'(vga_decode_en));
      chk("forward", 32'(shadow[1][2:0]), 32'({ct_lead_cycles, store_forward}));
      chk("arb", 32'(shadow[1][ARB_BIT]), 32'(arb_hold_grant));
      chk("credit", 32'(shadow[1][CRD_BIT]), 32'(credit_all_types));
      chk("order", 32'(shadow[1][6:5]), 32'({cpl_tag_ordering, egress_ordering}));
      chk("test_a", shadow[2], test_ctrl_a);
      chk("test_b", shadow[3], test_ctrl_b);
      $display("test %s done", t);
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   always @(negedge sys_clk) begin
      if (cfg_rvalid === 1'b1) begin
         if (expq.size() == 0)
            chk("rvalid", 32'h0, 32'h1);
         else
            chk("rdata", expq.pop_front(), cfg_rdata);
      end
   end

   // ****************************************
   // sequence
   // ****************************************
   initial begin
      r = $urandom(56423);
      model_reset();
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      ctl("reset");
      foreach (shadow[i])
         rd({4'h6 + 4'(i < 2), 2'(i), 2'h0});
      rd(8'h7c);
      for (int i = 0; i < 8; i++) begin
         wr(i[0] ? OFS_TEST_B : OFS_TEST_A, 4'($urandom), $urandom);
         rd(i[0] ? OFS_TEST_B : OFS_TEST_A);
      end
      ctl("test words");
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         wr(OFS_TIMER, 4'hf, i[2] ? (r | 32'h4000_1000) : (r & 32'hbfff_efff));
         rd(OFS_TIMER);
         ctl("timer");
      end
      for (int i = 0; i < 16; i++) begin
         r = $urandom;
         r[3:0] = 4'(i);
         wr(OFS_OPMODE, 4'hf, r);
         rd(OFS_OPMODE);
         ctl("opmode");
      end
      wr(8'h7c, 4'hf, 32'hffff_ffff);
      rd(8'h7c);
      rd(OFS_TEST_B);
      ld(OFS_TIMER, 32'h2abc_f123, 1'b0);
      rd(OFS_TIMER);
      ctl("default load");
      ld(OFS_OPMODE, 32'h0000_0055, 1'b1);
      rd(OFS_OPMODE);
      ctl("load priority");
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      model_reset();
      ctl("second reset");
      rd(OFS_TIMER);
      for (int k = 0; k < 20 && expq.size() > 0; k++)
         @(posedge sys_clk);
      if (expq.size() > 0)
         chk("pending reads", 32'h0, 32'(expq.size()));
      complete_run();
   end
endmodule
